// ===== src/fault_readout_regs.svh
// constants for the led fault detect and status read-out block
// assumes a 100 MHz system clock that samples the controller lines
`ifndef FAULT_READOUT_REGS_SVH
`define FAULT_READOUT_REGS_SVH
`define CHAN_COUNT        16
`define STATUS_RESET      16'h0000
`define DETECT_SETUP_NS   2000
`define CLK_PERIOD_NS     10
`define DETECT_SETUP_CYC  ((`DETECT_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_PULSE_NUM    3
`define CODE_FAULT        1'b0
`define CODE_NORMAL       1'b1
`endif

// ===== src/fault_readout_pkg.sv
// types for the led fault detect and status read-out block
// assumes nothing beyond the constants header
package fault_readout_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_OPEN,
        MODE_SHORT
    } mode_e;
    typedef struct packed {
        logic shift_clock;
        logic serial_in;
        logic latch_strobe;
        logic drive_enable_n;
    } ctrl_s;
endpackage

// ===== src/edge_detect.sv
// rising and falling edge detector for one controller line
// assumes the input is synchronous to clk_i
`timescale 1ns/1ps
module edge_detect (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic level_i,
    input  wire logic rise_init_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic last_q;
    logic last_d;
    // previous level only
    always_comb begin
        last_d = level_i;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // follow the pin in reset, so no false edge appears at release
            last_q <= level_i;
        end else begin
            last_q <= last_d;
        end
    end
    assign rise_o = level_i & ~last_q & ~rise_init_i;
    assign fall_o = ~level_i & last_q;
endmodule

// ===== src/fault_readout.sv
// led fault detection and serial status read-out, 16 channels
// assumes controller lines are synchronous to clk_i; a mode select input
// stands for the mode-entry sequence, which is not decoded here
`timescale 1ns/1ps
`include "fault_readout_regs.svh"
module fault_readout #(
    parameter int CHANNELS = `CHAN_COUNT
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  fault_readout_pkg::ctrl_s       ctrl_i,
    input  wire logic                      mode_entry_i,
    input  fault_readout_pkg::mode_e       mode_sel_i,
    input  wire logic [CHANNELS-1:0]       below_open_i,
    input  wire logic [CHANNELS-1:0]       above_short_i,
    output logic                           serial_out_o,
    output logic [CHANNELS-1:0]            drive_on_o,
    output logic                           detect_active_o,
    output logic                           setup_violation_o
);
    localparam int SETUP_CYC = `DETECT_SETUP_CYC;
    // the chain slice needs two bits; the setup counter is twelve bits wide
    if (CHANNELS < 2 || CHANNELS > 64) begin : g_bad_channels
        $error("CHANNELS out of range");
    end
    if (SETUP_CYC < 1 || SETUP_CYC > 4095) begin : g_bad_setup
        $error("setup count does not fit its counter");
    end

    ////////////////////////////////////////////////////////////////////
    logic sck_rise;
    logic sck_fall;
    logic en_rise;
    logic en_fall;
    logic lat_rise;
    edge_detect u_sck (.clk_i(clk_i), .rst_n_i(rst_n_i), .level_i(ctrl_i.shift_clock),
                       .rise_init_i(1'b0), .rise_o(sck_rise), .fall_o(sck_fall));
    edge_detect u_en (.clk_i(clk_i), .rst_n_i(rst_n_i), .level_i(ctrl_i.drive_enable_n),
                      .rise_init_i(1'b0), .rise_o(en_rise), .fall_o(en_fall));
    edge_detect u_lat (.clk_i(clk_i), .rst_n_i(rst_n_i), .level_i(ctrl_i.latch_strobe),
                       .rise_init_i(1'b0), .rise_o(lat_rise), .fall_o());

    ////////////////////////////////////////////////////////////////////
    fault_readout_pkg::mode_e mode_q;
    fault_readout_pkg::mode_e mode_d;
    logic [CHANNELS-1:0]      shift_q;
    logic [CHANNELS-1:0]      shift_d;
    logic [CHANNELS-1:0]      latch_q;
    logic [CHANNELS-1:0]      latch_d;
    logic [1:0]               pulse_q;
    logic [1:0]               pulse_d;
    logic [11:0]              setup_q;
    logic [11:0]              setup_d;
    logic                     viol_q;
    logic                     viol_d;
    logic                     serial_out_q;
    logic                     serial_out_d;
    logic                     detecting;
    logic [CHANNELS-1:0]      status;
    logic [1:0]               pulse_now;

    assign detecting = (mode_q != fault_readout_pkg::MODE_NORMAL) && !ctrl_i.drive_enable_n;

    // an enable fall restarts the count even when a clock rise meets it,
    // otherwise a stale count from an aborted cycle could load too early
    assign pulse_now = en_fall ? 2'd0 : pulse_q;

    // per-channel code, 0 marks a fault
    always_comb begin
        status = {CHANNELS{`CODE_NORMAL}};
        for (int i = 0; i < CHANNELS; i++) begin
            if (mode_q == fault_readout_pkg::MODE_OPEN && below_open_i[i]) begin
                status[i] = `CODE_FAULT;
            end
            if (mode_q == fault_readout_pkg::MODE_SHORT && above_short_i[i]) begin
                status[i] = `CODE_FAULT;
            end
        end
    end

    // mode, chain, latch and detect-cycle counters
    always_comb begin
        mode_d  = mode_q;
        shift_d = shift_q;
        latch_d = latch_q;
        pulse_d = pulse_q;
        setup_d = setup_q;
        viol_d  = viol_q;
        serial_out_d  = serial_out_q;
        if (mode_entry_i) begin
            mode_d = mode_sel_i;
        end
        // strobe is a latch command only outside mode entry
        if (lat_rise && !mode_entry_i) begin
            latch_d = shift_q;
        end
        // count starts at one: the fall is seen a cycle late, as is a clock rise,
        // so the counter then holds the true spacing in clock periods
        if (en_fall) begin
            pulse_d = 2'd0;
            setup_d = 12'd1;
        end else if (detecting && setup_q != 12'(SETUP_CYC)) begin
            setup_d = setup_q + 12'd1;
        end
        if (sck_rise) begin
            if (detecting) begin
                if (pulse_now != 2'd3) begin
                    pulse_d = pulse_now + 2'd1;
                end
                if (pulse_now == 2'(`LOAD_PULSE_NUM - 1)) begin
                    shift_d = status;
                    // third clock too early is flagged
                    viol_d  = (setup_q < 12'(SETUP_CYC));
                end
            end else begin
                // shift out one bit per clock
                // same order as the normal chain
                shift_d = {shift_q[CHANNELS-2:0], ctrl_i.serial_in};
            end
        end
        // serial out updates on a clock fall or an enable rise, msb of chain
        if (sck_fall || en_rise) begin
            serial_out_d = shift_q[CHANNELS-1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_q  <= fault_readout_pkg::MODE_NORMAL;
            shift_q <= CHANNELS'(`STATUS_RESET);
            latch_q <= CHANNELS'(`STATUS_RESET);
            pulse_q <= 2'd0;
            setup_q <= 12'd0;
            viol_q  <= 1'b0;
            serial_out_q  <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            shift_q <= shift_d;
            latch_q <= latch_d;
            pulse_q <= pulse_d;
            setup_q <= setup_d;
            viol_q  <= viol_d;
            serial_out_q  <= serial_out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs drive while enable is low, detect or not
    assign drive_on_o        = ctrl_i.drive_enable_n ? '0 : latch_q;
    assign serial_out_o      = serial_out_q;
    assign detect_active_o   = detecting;
    assign setup_violation_o = viol_q;

    ////////////////////////////////////////////////////////////////////
    // the two kinds of clock rise inside a detection cycle
    sequence seq_third_rise;
        detecting && sck_rise && pulse_now == 2'd2;
    endsequence
    sequence seq_other_rise;
        detecting && sck_rise && pulse_now != 2'd2;
    endsequence

    // capture and hold of the chain while detecting, and clock count restart
    chk_load_third: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_third_rise |=> shift_q == $past(status))
        else $error("status not loaded on third clock");
    chk_sin_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_other_rise |=> $stable(shift_q))
        else $error("chain moved while detecting");
    chk_count_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        en_fall && !sck_rise |=> pulse_q == 2'd0)
        else $error("clock count not restarted");

    // latch behaviour inside and outside mode entry
    chk_no_latch_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_entry_i |=> $stable(latch_q))
        else $error("latch changed during mode entry");
    chk_latch_normal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        lat_rise && !mode_entry_i |=> latch_q == $past(shift_q))
        else $error("strobe outside mode entry did not latch");

    // status codes per mode, and output drive
    chk_open_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_q == fault_readout_pkg::MODE_OPEN |-> status == ~below_open_i)
        else $error("open code wrong");
    chk_short_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_q == fault_readout_pkg::MODE_SHORT |-> status == ~above_short_i)
        else $error("short code wrong");
    chk_drive_detect: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        detecting |-> drive_on_o == latch_q)
        else $error("no drive while detecting");
    chk_drive_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctrl_i.drive_enable_n |-> drive_on_o == '0)
        else $error("outputs driven with enable high");

    // read-out: chain shifts on the rise, serial out follows on the fall and on the enable rise
    chk_shift_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !detecting && sck_rise |=> shift_q[CHANNELS-1:1] == $past(shift_q[CHANNELS-2:0]))
        else $error("status not shifted");
    chk_serial_out_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sck_fall |=> serial_out_o == $past(shift_q[CHANNELS-1]))
        else $error("serial out not updated on clock fall");
    chk_serial_out_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        en_rise |=> serial_out_o == $past(shift_q[CHANNELS-1]))
        else $error("first status bit not shown at enable rise");

    // setup flag: set when early, cleared when on time
    chk_early_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_third_rise ##0 (setup_q < 12'(SETUP_CYC)) |=> viol_q)
        else $error("early third clock not flagged");
    chk_late_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_third_rise ##0 (setup_q >= 12'(SETUP_CYC)) |=> !viol_q)
        else $error("timely third clock flagged");
endmodule

// ===== tb/fault_ctrl_model.sv
// controller model: mode entry, detection cycle and status read-out
// assumes the bench calls its tasks just after a rising edge of clk_i
`timescale 1ns/1ps
module fault_ctrl_model (
    input  wire logic                 clk_i,
    input  wire logic                 serial_out_i,
    output fault_readout_pkg::ctrl_s  ctrl_o,
    output logic                      mode_entry_o,
    output fault_readout_pkg::mode_e  mode_sel_o
);
    // idle lines: clock low, enable high
    initial begin
        ctrl_o = 4'h1;
        mode_entry_o = 1'b0;
        mode_sel_o = fault_readout_pkg::MODE_NORMAL;
    end
    ////////////////////////////////////////////////////////////////////
    // one pulse; serial_in toggles so any leak into the chain shows
    task automatic pulse();
        ctrl_o.serial_in   <= ~ctrl_o.serial_in;
        ctrl_o.shift_clock <= 1'b1;
        repeat (4) @(posedge clk_i);
        ctrl_o.shift_clock <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    // plain strobe outside mode entry, which latches the chain
    task automatic strobe();
        ctrl_o.latch_strobe <= 1'b1;
        repeat (2) @(posedge clk_i);
        ctrl_o.latch_strobe <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // mode entry with a strobe inside it
    task automatic enter(input fault_readout_pkg::mode_e m);
        mode_entry_o <= 1'b1;
        mode_sel_o   <= m;
        @(posedge clk_i);
        ctrl_o.latch_strobe <= 1'b1;
        repeat (2) @(posedge clk_i);
        ctrl_o.latch_strobe <= 1'b0;
        @(posedge clk_i);
        mode_entry_o <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic en_low();
        ctrl_o.drive_enable_n <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // third pulse after the gap; a fourth one probes serial_in
    task automatic capture(input int gap);
        pulse();
        pulse();
        repeat (gap) @(posedge clk_i);
        pulse();
        pulse();
        ctrl_o.drive_enable_n <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    // sixteen pulses, first bit out first
    task automatic read(output logic [15:0] w);
        w = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            w = {w[14:0], serial_out_i};
            pulse();
        end
    endtask
endmodule

// ===== tb/led_driver_fault_detect_readout_bench.sv
// bench for the fault detect and status read-out block
// assumes the controller model drives every control line
`timescale 1ns/1ps
`include "fault_readout_regs.svh"
module led_driver_fault_detect_readout_bench;
    logic                     clk_i    = 1'b0;
    logic                     rst_n_i  = 1'b0;
    logic [15:0]              below    = 16'h0000;
    logic [15:0]              above    = 16'h0000;
    fault_readout_pkg::ctrl_s ctrl;
    fault_readout_pkg::mode_e msel;
    logic                     mentry, serial_out, active, viol;
    logic [15:0]              drive, word;
    int                       n_errors = 0;
    int                       num_checks = 0;
    always #5 clk_i = ~clk_i;
    fault_readout i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl),
        .mode_entry_i(mentry), .mode_sel_i(msel), .below_open_i(below),
        .above_short_i(above), .serial_out_o(serial_out), .drive_on_o(drive),
        .detect_active_o(active), .setup_violation_o(viol));
    fault_ctrl_model i_ctrl (.clk_i(clk_i), .serial_out_i(serial_out), .ctrl_o(ctrl),
        .mode_entry_o(mentry), .mode_sel_o(msel));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // chain aaaa is latched, then moved to 5555; a strobe during entry does not latch, so drive keeps aaaa
    task automatic test_open();
        below <= 16'hA5C3;
        above <= 16'hFFFF;
        repeat (16) i_ctrl.pulse();
        i_ctrl.strobe();
        check("drive off", 16'h0000, drive);
        i_ctrl.pulse();
        i_ctrl.enter(fault_readout_pkg::MODE_OPEN);
        i_ctrl.en_low();
        check("active", 16'h0001, {15'h0, active});
        check("drive", 16'hAAAA, drive);
        i_ctrl.capture(`DETECT_SETUP_CYC);
        check("violation", 16'h0000, {15'h0, viol});
        i_ctrl.read(word);
        check("open word", 16'h5A3C, word);
    endtask
    task automatic test_short();
        below <= 16'hFFFF;
        above <= 16'h0F01;
        i_ctrl.enter(fault_readout_pkg::MODE_SHORT);
        i_ctrl.en_low();
        check("active", 16'h0001, {15'h0, active});
        // en_low and two pulses take 18 cycles: third rise exactly at the setup time
        i_ctrl.capture(`DETECT_SETUP_CYC - 18);
        check("violation", 16'h0000, {15'h0, viol});
        i_ctrl.read(word);
        check("short word", 16'hF0FE, word);
    endtask
    // third pulse one cycle early, then normal mode leaves detection off
    task automatic test_setup();
        i_ctrl.enter(fault_readout_pkg::MODE_OPEN);
        i_ctrl.en_low();
        i_ctrl.capture(`DETECT_SETUP_CYC - 19);
        check("violation", 16'h0001, {15'h0, viol});
        check("active", 16'h0000, {15'h0, active});
        i_ctrl.enter(fault_readout_pkg::MODE_NORMAL);
        i_ctrl.en_low();
        check("normal active", 16'h0000, {15'h0, active});
        check("normal drive", 16'hAAAA, drive);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        test_open();
        test_short();
        test_setup();
        print_verdict();
    end
    // watchdog well beyond the roughly 1100 cycles expected
    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end
endmodule
